// ===== core/nfh_host.sv
`timescale 1ns/1ns
module nfh_host
  import nfh_pkg::*;
#(
  parameter int ADDR_WIDTH = ADDR_W
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  req_valid_i,
  input  wire nfh_req_t              req_i,
  input  wire logic                  byte_mode_i,
  input  wire logic                  status_read_i,
  output logic                       req_ready_o,
  output logic                       rdata_valid_o,
  output logic [DATA_W-1:0]          rdata_o,
  output logic                       dev_busy_o,
  output logic                       flash_rst_n_o,
  output logic                       chip_sel_n_o,
  output logic                       out_en_n_o,
  output logic                       wr_strobe_n_o,
  output logic                       width_sel_o,
  output logic [ADDR_WIDTH-1:0]      addr_o,
  output logic [DATA_W-1:0]          dq_o,
  output logic [DATA_W-1:0]          dq_oe_o,
  input  wire logic [DATA_W-1:0]     dq_i,
  input  wire logic                  op_done_flag_i
);

  nfh_state_t        state_ff;
  logic [CNT_W-1:0]  cnt_ff;
  logic              wr_ff;
  logic              stat_ff;
  logic              mode_ff;
  logic [DATA_W-1:0] dq_s1_ff;
  logic [DATA_W-1:0] dq_s2_ff;
  logic              busy_s1_ff;
  logic              busy_s2_ff;

  // Pin inputs pass two flops before any logic reads them.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dq_s1_ff   <= '0;
      dq_s2_ff   <= '0;
      busy_s1_ff <= 1'b1;
      busy_s2_ff <= 1'b1;
    end else begin
      dq_s1_ff   <= dq_i;
      dq_s2_ff   <= dq_s1_ff;
      busy_s1_ff <= op_done_flag_i;
      busy_s2_ff <= busy_s1_ff;
    end
  end

  // A wired-or line low means some device is still working.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dev_busy_o <= 1'b0;
    end else begin
      dev_busy_o <= !busy_s2_ff;
    end
  end

  // Bus sequencer; each phase holds for its cycle count.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff      <= NFH_RESET;
      cnt_ff        <= '0;
      wr_ff         <= 1'b0;
      stat_ff       <= 1'b0;
      mode_ff       <= 1'b0;
      req_ready_o   <= 1'b0;
      rdata_valid_o <= 1'b0;
      rdata_o       <= '0;
      flash_rst_n_o <= 1'b0;
      chip_sel_n_o  <= 1'b1;
      out_en_n_o    <= 1'b1;
      wr_strobe_n_o <= 1'b1;
      width_sel_o   <= 1'b0;
      addr_o        <= '0;
      dq_o          <= '0;
      dq_oe_o       <= '0;
    end else begin
      rdata_valid_o <= 1'b0;
      case (state_ff)
        NFH_RESET: begin
          // The flash reset pin is held low for the full minimum pulse.
          flash_rst_n_o <= 1'b0;
          if (cnt_ff >= CNT_W'(RESET_PULSE_CYC - 1)) begin
            cnt_ff        <= '0;
            flash_rst_n_o <= 1'b1;
            state_ff      <= NFH_RECOVER;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
        NFH_RECOVER: begin
          // The longer of both recovery times passes before any access.
          if (cnt_ff >= CNT_W'(RECOVERY_CYC - 1)) begin
            cnt_ff      <= '0;
            req_ready_o <= 1'b1;
            state_ff    <= NFH_IDLE;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
        NFH_IDLE: begin
          if (req_valid_i) begin
            req_ready_o <= 1'b0;
            wr_ff       <= req_i.write;
            stat_ff     <= status_read_i;
            mode_ff     <= byte_mode_i;
            // Width select is latched per transfer so it cannot move mid-write.
            width_sel_o <= !byte_mode_i;
            addr_o      <= req_i.addr[ADDR_WIDTH-1:0];
            dq_o        <= req_i.wdata;
            // In byte mode the top pin becomes the lowest address bit.
            if (byte_mode_i) begin
              dq_o[TOP_BIT] <= req_i.addr[0];
              addr_o        <= {1'b0, req_i.addr[ADDR_WIDTH-1:1]};
            end
            // Writes drive the low byte; upper data only in word mode.
            dq_oe_o <= req_i.write ? (byte_mode_i ? 16'h80ff : 16'hffff)
                                   : (byte_mode_i ? 16'h8000 : 16'h0000);
            chip_sel_n_o <= 1'b0;
            cnt_ff       <= '0;
            state_ff     <= NFH_SETUP;
          end
        end
        NFH_SETUP: begin
          // Output enable stays high through a write; strobe falls after setup.
          if (wr_ff) begin
            out_en_n_o    <= 1'b1;
            wr_strobe_n_o <= 1'b0;
            state_ff      <= NFH_STROBE;
          end else begin
            out_en_n_o    <= 1'b0;
            wr_strobe_n_o <= 1'b1;
            state_ff      <= NFH_ACCESS;
          end
          cnt_ff <= '0;
        end
        NFH_ACCESS: begin
          // Wait access plus two synchroniser cycles before sampling.
          if (cnt_ff >= CNT_W'(ACCESS_CYC + 1)) begin
            rdata_valid_o <= 1'b1;
            rdata_o       <= dq_s2_ff;
            // Upper lines carry nothing in byte mode or in polling status.
            if (mode_ff || stat_ff) begin
              rdata_o[DATA_W-1:LOW_BYTE_W] <= '0;
            end
            out_en_n_o   <= 1'b1;
            chip_sel_n_o <= 1'b1;
            cnt_ff       <= '0;
            state_ff     <= NFH_HOLD;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
        NFH_STROBE: begin
          // Data is stable across the rising strobe edge that latches it.
          if (cnt_ff >= CNT_W'(STROBE_CYC - 1)) begin
            wr_strobe_n_o <= 1'b1;
            cnt_ff        <= '0;
            state_ff      <= NFH_HOLD;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
        NFH_HOLD: begin
          // Release data, and select after a write, one cycle after the closing edge.
          chip_sel_n_o <= 1'b1;
          if (cnt_ff >= CNT_W'(SETUP_CYC - 1)) begin
            dq_oe_o     <= '0;
            req_ready_o <= 1'b1;
            cnt_ff      <= '0;
            state_ff    <= NFH_IDLE;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
        default: begin
          state_ff <= NFH_RESET;
        end
      endcase
    end
  end

  // Output enable and write strobe are never low together.
  chk_oe_we_excl: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(!out_en_n_o && !wr_strobe_n_o)) else $error("Output enable low during write.");

  // Strobe low always lasts exactly the strobe width.
  sequence s_strobe_fall;
    $fell(wr_strobe_n_o);
  endsequence
  chk_strobe_width: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_strobe_fall |-> !wr_strobe_n_o [*2] ##1 wr_strobe_n_o) else $error("Bad strobe width.");

  // Select is low whenever a read or write strobe is active.
  chk_sel_active: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!out_en_n_o || !wr_strobe_n_o) |-> !chip_sel_n_o) else $error("Access without select.");

  // Reset pin stays low for the minimum pulse after reset release.
  chk_reset_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(flash_rst_n_o) |-> $past(rst_n_i, 4) && !$past(flash_rst_n_o, 4))
    else $error("Reset pulse short.");

  // No access starts until recovery has passed.
  chk_recovery_gap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(flash_rst_n_o) |-> chip_sel_n_o [*4]) else $error("Access during recovery.");

  // Width select does not move while the strobe is low.
  chk_width_stable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !wr_strobe_n_o |-> $stable(width_sel_o)) else $error("Width select moved in write.");

  // Busy output follows the line through two sync stages.
  chk_busy_track: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    dev_busy_o == !$past(op_done_flag_i, 3) || $past(!rst_n_i, 3))
    else $error("Busy flag mismatch.");

  // Byte-mode reads return zero upper lines.
  chk_upper_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rdata_valid_o && !width_sel_o) |-> rdata_o[DATA_W-1:LOW_BYTE_W] == '0)
    else $error("Upper data set.");

endmodule : nfh_host

// ===== pkg/nfh_pkg.sv
package nfh_pkg;

  // Host-side timing figures in nanoseconds; the clock runs at 20 MHz.
  localparam int CLK_PERIOD_NS        = 50;
  localparam int RESET_PULSE_MIN_NS   = 200;  // Reset pulse minimum.
  localparam int RESET_TO_SELECT_NS   = 200;  // Reset release to chip select.
  localparam int RESET_TO_STROBE_NS   = 200;  // Reset release to write strobe.
  localparam int ACCESS_NS            = 100;  // Read access wait.
  localparam int STROBE_LOW_NS        = 100;  // Write strobe low width.
  localparam int SETUP_NS             = 50;   // Address setup and recovery.

  // Least times round up to whole cycles.
  localparam int RESET_PULSE_CYC  = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_NS      = (RESET_TO_SELECT_NS > RESET_TO_STROBE_NS) ?
                                    RESET_TO_SELECT_NS : RESET_TO_STROBE_NS;
  localparam int RECOVERY_CYC     = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC       = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC       = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC        = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W            = 8;
  localparam int ADDR_W           = 26;
  localparam int DATA_W           = 16;
  localparam int LOW_BYTE_W       = 8;
  localparam int TOP_BIT          = 15;

  // Host request carried as one packed group.
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } nfh_req_t;

  typedef enum logic [2:0] {
    NFH_RESET, NFH_RECOVER, NFH_IDLE, NFH_SETUP, NFH_ACCESS, NFH_STROBE, NFH_HOLD
  } nfh_state_t;

endpackage : nfh_pkg

// ===== verif/nfh_flash_model.sv
`timescale 1ns/1ns
// Behavioural flash device seen from its pins; a small byte memory stands behind the bus.
module nfh_flash_model
  import nfh_pkg::*;
#(
  parameter int BUSY_CYC   = 12,
  parameter int DEC_ADDR_W = 23
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              cs_n_i,
  input  wire logic              oe_n_i,
  input  wire logic              we_n_i,
  input  wire logic              width_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] hdq_i,
  input  wire logic [DATA_W-1:0] hoe_i,
  output logic      [DATA_W-1:0] dq_o,
  output logic                   rdy_o,
  output int                     faults_o
);
  // A fixed byte store keeps the model within what every simulator accepts.
  localparam int MEM_AW = 13;
  logic [7:0]        mem [0:(1<<MEM_AW)-1];
  logic [DATA_W-1:0] rd, drv;
  logic [ADDR_W-1:0] dec_addr;
  logic              junk, wsel_at_fall;
  int                ba, lat, busy;

  initial begin
    junk = 1'b0;
    lat = -1;
    busy = 0;
    faults_o = 0;
  end
  // Reserved upper address pins of a smaller density are not decoded.
  assign dec_addr = addr_i & ~({ADDR_W{1'b1}} << DEC_ADDR_W);
  // Byte address: the top pin is the lowest address bit in 8-bit mode.
  // It is taken from the host side so the address never loops through the model's own output.
  assign ba = width_i ? int'({dec_addr, 1'b0})
                      : int'({dec_addr, hdq_i[TOP_BIT]});
  assign rd = {mem[(ba + 1) % (1 << MEM_AW)], mem[ba % (1 << MEM_AW)]};
  // Buffers open only for a selected read out of reset; upper lines stay off in 8-bit mode.
  assign drv = (rst_n_i && !cs_n_i && !oe_n_i) ? (width_i ? 16'hffff : 16'h00ff)
                                               : 16'h0000;
  // Floating lines toggle every cycle so a stale value can never pass for data.
  assign dq_o = (hoe_i & hdq_i) | (~hoe_i & drv & rd) | (~hoe_i & ~drv & {DATA_W{junk}});
  assign rdy_o = (busy > 0) ? 1'b0 : 1'b1;
  // Address is taken at the later falling edge of select and strobe.
  always @(negedge we_n_i or negedge cs_n_i) begin
    if (!we_n_i && !cs_n_i && rst_n_i) begin
      lat = ba;
      wsel_at_fall = width_i;
      if (!oe_n_i) faults_o++;
    end
  end
  // Data is taken at the first rising edge; upper lines are ignored in 8-bit mode.
  always @(posedge we_n_i or posedge cs_n_i) begin
    if (lat >= 0) begin
      mem[lat % (1 << MEM_AW)] = dq_o[7:0];
      if (width_i) mem[(lat + 1) % (1 << MEM_AW)] = dq_o[15:8];
      if (width_i !== wsel_at_fall) faults_o++;
      lat = -1;
      busy = BUSY_CYC;
    end
  end
  // Program time counts down on the clock; reset abandons it.
  always @(posedge clk_i) begin
    junk <= ~junk;
    if (!rst_n_i) busy <= 0;
    else if (busy > 0) busy <= busy - 1;
  end
endmodule : nfh_flash_model

// ===== verif/testbench.sv
`timescale 1ns/1ns
module testbench;
  import nfh_pkg::*;
  logic              clk_i, rst_n_i, req_valid_i, byte_mode_i, status_read_i;
  logic              req_ready_o, rdata_valid_o, dev_busy_o, frst_n, cs_n, oe_n, we_n, wsel, rdy;
  logic [DATA_W-1:0] rdata_o, dq_o, dq_oe_o, dq_i, d;
  logic [ADDR_W-1:0] addr_o;
  logic [16:0]       expq [$];
  logic [16:0]       e;
  nfh_req_t          req_i;
  int                num_errors = 0, tests_run = 0, seed = 69374, cycles = 0, faults, a, n;

  nfh_host uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .byte_mode_i(byte_mode_i), .status_read_i(status_read_i), .req_ready_o(req_ready_o),
    .rdata_valid_o(rdata_valid_o), .rdata_o(rdata_o), .dev_busy_o(dev_busy_o),
    .flash_rst_n_o(frst_n), .chip_sel_n_o(cs_n), .out_en_n_o(oe_n), .wr_strobe_n_o(we_n),
    .width_sel_o(wsel), .addr_o(addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dq_i(dq_i),
    .op_done_flag_i(rdy));
  nfh_flash_model flash (.clk_i(clk_i), .rst_n_i(frst_n), .cs_n_i(cs_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .width_i(wsel), .addr_i(addr_o), .hdq_i(dq_o), .hoe_i(dq_oe_o),
    .dq_o(dq_i), .rdy_o(rdy), .faults_o(faults));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // One request, held until taken; a read leaves its expected answer in the queue.
  task automatic xfer(input logic wr, input int ad, input logic [15:0] dt, input logic bm,
                      input logic st);
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_i <= '{write: wr, addr: ad[ADDR_W-1:0], wdata: dt};
    byte_mode_i <= bm;
    status_read_i <= st;
    if (!wr) expq.push_back({bm, (bm || st) ? {8'h00, dt[7:0]} : dt});
    do @(negedge clk_i); while (req_ready_o !== 1'b1);
    @(posedge clk_i);
    req_valid_i <= 1'b0;
  endtask : xfer

  // Width changes only while the host is idle, so no write sees it move.
  task automatic wait_idle();
    do @(negedge clk_i); while (req_ready_o !== 1'b1);
  endtask : wait_idle

  // Each read result is compared with the oldest expectation.
  always @(negedge clk_i) begin
    if (rdata_valid_o === 1'b1) begin
      check(expq.size() > 0, "read data without request");
      if (expq.size() > 0) begin
        e = expq.pop_front();
        // Upper lines are expected cleared in byte mode, so the whole word is compared.
        if (e[16]) check(rdata_o === e[15:0], "byte read data");
        else check(rdata_o === e[15:0], "word read data");
      end
    end
  end

  // Cycle ceiling guards against a hang.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      check(1'b0, "timeout");
      finish_test();
    end
  end

  initial begin
    rst_n_i = 1'b0;
    req_valid_i = 1'b0;
    req_i = '0;
    byte_mode_i = 1'b0;
    status_read_i = 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    check(frst_n === 1'b0 && cs_n === 1'b1 && dq_oe_o === 16'h0000, "pins in reset");
    // Release on the third rising edge; the flops still see reset at that edge.
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    wait_idle();
    check(frst_n === 1'b1 && cs_n === 1'b1, "idle after recovery");
    // Word mode: write, read back, then a status read with the upper byte cleared.
    for (int i = 0; i < 4; i++) begin
      a = $random(seed) & 'hfff;
      d = 16'($random(seed));
      xfer(1'b1, a, d, 1'b0, 1'b0);
      if (i == 0) begin
        n = 0;
        while (dev_busy_o !== 1'b1 && n < 30) begin
          @(negedge clk_i);
          n++;
        end
        check(dev_busy_o === 1'b1, "busy not reported");
        // The line must also come back once programming is over.
        n = 0;
        while (dev_busy_o !== 1'b0 && n < 40) begin
          @(negedge clk_i);
          n++;
        end
        check(dev_busy_o === 1'b0, "busy not released");
      end
      xfer(1'b0, a, d, 1'b0, 1'b0);
      xfer(1'b0, a, d, 1'b0, 1'b1);
    end
    wait_idle();
    // Byte mode at both parities exercises the top pin as lowest address bit.
    for (int i = 0; i < 4; i++) begin
      a = ($random(seed) & 'h1fe) | (i & 1);
      d = 16'($random(seed));
      xfer(1'b1, a, d, 1'b1, 1'b0);
      xfer(1'b0, a, d, 1'b1, 1'b0);
    end
    n = 0;
    while (expq.size() > 0 && n < 50) begin
      @(negedge clk_i);
      n++;
    end
    check(expq.size() == 0, "reads left unanswered");
    check(faults == 0, "host broke write timing");
    finish_test();
  end
endmodule : testbench
